// ===== hsbc_pkg.sv
// constants and state codes for the hub sideband control pins
//
// Functional notes
// - communication stage entered only while hub connect input is high.
// - connect tied high: enter communication automatically once configuration finishes.
// - connect driven low-to-high: enter after configuration done and rising edge seen.
// - drive configurable two-bit charger detect output limiting upstream current.
// - assert suspend indication when the whole hub is suspended.
// - suspend indication works only when enabled by configuration.
// - low level on interrupt request input is an asserted request.
// - interrupt output pulled low while pending, released otherwise.
// - one port control pin serves as power enable and over-current sense.
// - strap levels captured at power-on and each external reset release.
package hsbc_pkg;
  // ****************************************
  // stage sequencing
  // ****************************************
  typedef enum logic [2:0] {
    HSBC_ST_CONFIG = 3'h1,
    HSBC_ST_WAIT   = 3'h2,
    HSBC_ST_COMM   = 3'h4
  } hsbc_stage_t;

  // ****************************************
  // straps and timing
  // ****************************************
  localparam int          STRAP_W         = 4;
  localparam logic [3:0]  STRAP_RST       = 4'h0;
  localparam logic [1:0]  CHG_DET_RST     = 2'h0;
  localparam int          CLK_FREQ_HZ     = 10_000_000;
  localparam int          RST_MIN_US      = 5;
  localparam int          RST_MIN_CYC     = (RST_MIN_US * CLK_FREQ_HZ + 999_999) / 1_000_000;
  localparam int          OC_SYNC_W       = 2;
endpackage : hsbc_pkg

// ===== hsbc_strap_latch.sv
// strap capture on power-on and on each external reset release
`timescale 1ns/10ps
module hsbc_strap_latch (
  input  wire logic                        clk_sys,     // system clock
  input  wire logic                        rstn,        // sync reset, active low
  input  wire logic [hsbc_pkg::STRAP_W-1:0] strap_in,   // strap pin levels
  output logic      [hsbc_pkg::STRAP_W-1:0] strap_q,    // held strap values
  output logic                             strap_valid  // straps captured
);
  logic [hsbc_pkg::STRAP_W-1:0] strap_r;
  logic [hsbc_pkg::STRAP_W-1:0] strap_nxt;
  logic                         in_rst_r;
  logic                         in_rst_nxt;
  logic                         valid_r;
  logic                         valid_nxt;

  // capture on first clocked edge after release, never under reset itself
  always_comb begin
    strap_nxt  = strap_r;
    in_rst_nxt = 1'b0;
    valid_nxt  = valid_r;
    if (in_rst_r) begin
      strap_nxt = strap_in;
      valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      strap_r  <= hsbc_pkg::STRAP_RST;
      in_rst_r <= 1'b1;
      valid_r  <= 1'b0;
    end else begin
      strap_r  <= strap_nxt;
      in_rst_r <= in_rst_nxt;
      valid_r  <= valid_nxt;
    end
  end

  assign strap_q     = strap_r;
  assign strap_valid = valid_r;
endmodule : hsbc_strap_latch

// ===== hsbc_top.sv
// hub sideband control: connect gating, suspend, charger detect, irq, port control
`timescale 1ns/10ps
module hsbc_top (
  input  wire logic                        clk_sys,          // system clock, 10 MHz
  input  wire logic                        rstn,             // sync reset, active low
  input  wire logic [hsbc_pkg::STRAP_W-1:0] strap_in,        // strap pin levels
  input  wire logic                        config_done,      // configuration phase finished
  input  wire logic                        hub_connect_in,   // hub connect pin
  output logic                             comm_stage,       // hub in communication stage
  input  wire logic                        suspend_enable,   // configuration enables suspend pin
  input  wire logic                        hub_suspended,    // whole hub in suspend state
  output logic                             suspend_out,      // suspend indication
  input  wire logic [1:0]                  charger_cfg,      // configured charger detect code
  output logic                             charger_detect_bit0, // charger detect bit 0
  output logic                             charger_detect_bit1, // charger detect bit 1
  input  wire logic                        irq_in_n,         // interrupt request in, low active
  output logic                             irq_req,          // request seen by the core
  input  wire logic                        int_pending,      // core has an interrupt pending
  output logic                             int_out_o,        // open-drain output value
  output logic                             int_out_oe,       // open-drain enable, high drives
  input  wire logic                        port_power_enable,// core wants port power on
  input  wire logic                        port_control_pin_i, // port control pin level
  output logic                             port_control_pin_o, // port control pin drive value
  output logic                             port_control_pin_oe,// port control pin enable
  output logic                             port_overcurrent,  // over-current seen
  output logic [hsbc_pkg::STRAP_W-1:0]     strap_q            // latched straps
);
  // ****************************************
  // straps
  // ****************************************
  logic [hsbc_pkg::STRAP_W-1:0] strap_w;
  logic                         strap_valid_w;

  // the connect sequencer waits on strap_valid so it never acts on straps
  // that are still being captured
  hsbc_strap_latch u_strap (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .strap_in    (strap_in),
    .strap_q     (strap_w),
    .strap_valid (strap_valid_w)
  );

  // ****************************************
  // connect sequencing
  // ****************************************
  hsbc_pkg::hsbc_stage_t stage_r;
  hsbc_pkg::hsbc_stage_t stage_nxt;
  logic                  conn_prev_r;
  logic                  conn_prev_nxt;
  logic                  comm_r;
  logic                  comm_nxt;

  // a high seen as configuration finishes counts as tied high; a low seen means
  // software-style control, so wait for the rising edge
  always_comb begin
    stage_nxt     = stage_r;
    conn_prev_nxt = hub_connect_in;
    unique case (stage_r)
      hsbc_pkg::HSBC_ST_CONFIG: begin
        if (config_done && strap_valid_w) begin
          if (hub_connect_in) begin
            stage_nxt = hsbc_pkg::HSBC_ST_COMM;
          end else begin
            stage_nxt = hsbc_pkg::HSBC_ST_WAIT;
          end
        end
      end
      hsbc_pkg::HSBC_ST_WAIT: begin
        // conn_prev_r follows the pin in every state, so only a rise seen
        // while waiting here lets the hub enter the communication stage
        if (hub_connect_in && !conn_prev_r) begin
          stage_nxt = hsbc_pkg::HSBC_ST_COMM;
        end
      end
      hsbc_pkg::HSBC_ST_COMM: begin
        // leaving on a low keeps the stage tied to the pin level
        if (!hub_connect_in) begin
          stage_nxt = hsbc_pkg::HSBC_ST_WAIT;
        end
      end
      default: stage_nxt = hsbc_pkg::HSBC_ST_CONFIG;
    endcase
    comm_nxt = (stage_nxt == hsbc_pkg::HSBC_ST_COMM);
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      stage_r     <= hsbc_pkg::HSBC_ST_CONFIG;
      conn_prev_r <= 1'b0;
      comm_r      <= 1'b0;
    end else begin
      stage_r     <= stage_nxt;
      conn_prev_r <= conn_prev_nxt;
      comm_r      <= comm_nxt;
    end
  end

  // ****************************************
  // suspend indication
  // ****************************************
  // the pin stays low unless configuration enables it, so a board that
  // leaves it unused never sees a stray suspend report
  logic susp_r;
  logic susp_nxt;

  always_comb begin
    susp_nxt = suspend_enable && hub_suspended;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      susp_r <= 1'b0;
    end else begin
      susp_r <= susp_nxt;
    end
  end

  // ****************************************
  // charger detect
  // ****************************************
  // the code is registered so both bits change on the same edge and the
  // system never reads a mixed code
  logic [1:0] chg_r;
  logic [1:0] chg_nxt;

  always_comb begin
    chg_nxt = charger_cfg;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      chg_r <= hsbc_pkg::CHG_DET_RST;
    end else begin
      chg_r <= chg_nxt;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  // request in is active low; the core sees an active-high level a cycle late
  // interrupt out is open drain: driven low while pending, released otherwise
  logic irq_r;
  logic irq_nxt;
  logic int_oe_r;
  logic int_oe_nxt;

  always_comb begin
    irq_nxt    = !irq_in_n;
    int_oe_nxt = int_pending;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      irq_r    <= 1'b0;
      int_oe_r <= 1'b0;
    end else begin
      irq_r    <= irq_nxt;
      int_oe_r <= int_oe_nxt;
    end
  end

  // ****************************************
  // port power enable
  // ****************************************
  // open drain: pulled low holds power off; released lets the pull-up
  // enable power, so reset leaves the port unpowered
  logic pc_oe_r;
  logic pc_oe_nxt;

  always_comb begin
    pc_oe_nxt = !port_power_enable;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pc_oe_r <= 1'b1;
    end else begin
      pc_oe_r <= pc_oe_nxt;
    end
  end

  // ****************************************
  // over-current sense
  // ****************************************
  // a low pin is only a genuine over-current report while the hub has released
  // it; the sync stages add latency, but a switch fault lasts far longer
  logic [hsbc_pkg::OC_SYNC_W-1:0] oc_sync_r;
  logic [hsbc_pkg::OC_SYNC_W-1:0] oc_sync_nxt;
  logic                           oc_r;
  logic                           oc_nxt;

  always_comb begin
    oc_sync_nxt = {oc_sync_r[0], port_control_pin_i};
    oc_nxt      = !pc_oe_r && !oc_sync_r[hsbc_pkg::OC_SYNC_W-1];
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      oc_sync_r <= '1;
      oc_r      <= 1'b0;
    end else begin
      oc_sync_r <= oc_sync_nxt;
      oc_r      <= oc_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // both drive values stay low: the pins are open drain and only their
  // enables move
  assign comm_stage          = comm_r;
  assign suspend_out         = susp_r;
  assign charger_detect_bit0 = chg_r[0];
  assign charger_detect_bit1 = chg_r[1];
  assign irq_req             = irq_r;
  assign int_out_o           = 1'b0;
  assign int_out_oe          = int_oe_r;
  assign port_control_pin_o  = 1'b0;
  assign port_control_pin_oe = pc_oe_r;
  assign port_overcurrent    = oc_r;
  assign strap_q             = strap_w;
endmodule : hsbc_top

// ===== hsbc_monitor.sv
// concurrent checks on the hub sideband control pin ports
`timescale 1ns/10ps
module hsbc_monitor (
  input wire logic                         clk_sys,             // system clock
  input wire logic                         rstn,                // sync reset, active low
  input wire logic                         config_done,         // configuration finished
  input wire logic                         hub_connect_in,      // hub connect pin
  input wire logic                         comm_stage,          // communication stage
  input wire logic                         suspend_enable,      // suspend pin enabled
  input wire logic                         hub_suspended,       // hub suspended
  input wire logic                         suspend_out,         // suspend indication
  input wire logic                         irq_in_n,            // request in, low active
  input wire logic                         irq_req,             // request to the core
  input wire logic                         int_pending,         // core interrupt pending
  input wire logic                         int_out_o,           // interrupt drive value
  input wire logic                         int_out_oe,          // interrupt drive enable
  input wire logic                         port_power_enable,   // core wants port power
  input wire logic                         port_control_pin_i,  // port pin level
  input wire logic                         port_control_pin_oe, // port pin drive enable
  input wire logic                         port_overcurrent,    // over-current seen
  input wire logic                         charger_detect_bit0, // charger detect bit 0
  input wire logic                         charger_detect_bit1, // charger detect bit 1
  input wire logic [1:0]                   charger_cfg,         // configured charger code
  input wire logic [hsbc_pkg::STRAP_W-1:0] strap_in,            // strap pin levels
  input wire logic [hsbc_pkg::STRAP_W-1:0] strap_q              // latched straps
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ****************************************
  // pin relations
  // ****************************************
  AST_CONN_LOW: assert property (!hub_connect_in |=> !comm_stage)
    else $error("comm stage with connect low");
  AST_CONN_TIED: assert property ((config_done && hub_connect_in)[*3] |=> comm_stage)
    else $error("comm stage not entered");
  AST_CONN_RISE: assert property ($rose(comm_stage) |-> $past(config_done) && $past(hub_connect_in))
    else $error("comm stage without cause");
  AST_CHG: assert property (1 |=> {charger_detect_bit1, charger_detect_bit0} == $past(charger_cfg))
    else $error("charger bits wrong");
  AST_SUSP_ON: assert property (suspend_enable && hub_suspended |=> suspend_out)
    else $error("suspend not shown");
  AST_SUSP_OFF: assert property (!suspend_enable || !hub_suspended |=> !suspend_out)
    else $error("suspend shown wrongly");
  AST_IRQ: assert property (1 |=> irq_req == !$past(irq_in_n))
    else $error("irq request wrong");
  AST_INT: assert property (1 |=> int_out_oe == $past(int_pending) && !int_out_o)
    else $error("interrupt pin wrong");
  AST_PWR: assert property (1 |=> port_control_pin_oe == !$past(port_power_enable))
    else $error("port power drive wrong");
  AST_OC: assert property ((!port_control_pin_oe && !port_control_pin_i)[*5] |-> port_overcurrent)
    else $error("over-current missed");
  AST_STRAP_CAP: assert property ($rose(rstn) |=> strap_q == $past(strap_in))
    else $error("strap not captured");
  AST_STRAP_HOLD: assert property (rstn && $past(rstn) |=> $stable(strap_q))
    else $error("strap not held");
endmodule : hsbc_monitor

bind hsbc_top hsbc_monitor u_mon (.*);

// ===== hsbc_sys_model.sv
// port power switch and interrupt source beside the hub pins
`timescale 1ns/10ps
module hsbc_sys_model (
  input  wire logic pin_oe,    // hub drives the port pin
  input  wire logic pin_o,     // hub drive value while enabled
  input  wire logic fault,     // switch flags over-current
  input  wire logic irq_ask,   // system wants to interrupt the hub
  output logic      pin_level, // resolved port pin level
  output logic      irq_n      // interrupt request line
);
  // pull-up wins unless the hub or a faulting switch pulls low
  assign pin_level = (pin_oe ? pin_o : 1'b1) && !fault;
  assign irq_n     = !irq_ask;
endmodule : hsbc_sys_model

// ===== hsbc_tb_top.sv
// self-checking bench for the hub sideband control pins
`timescale 1ns/10ps
module hsbc_tb_top;
  logic       clk_sys, rstn, config_done, hub_connect_in, comm_stage, suspend_enable;
  logic       hub_suspended, suspend_out, charger_detect_bit0, charger_detect_bit1;
  logic       irq_in_n, irq_req, int_pending, int_out_o, int_out_oe, port_power_enable;
  logic       port_control_pin_i, port_control_pin_o, port_control_pin_oe, port_overcurrent;
  logic       fault, irq_ask, int_wire;
  logic [1:0] charger_cfg;
  logic [3:0] strap_in, strap_q;
  int         bad_count, tests_run;

  hsbc_top dut (.*);
  hsbc_sys_model u_sys (.pin_oe(port_control_pin_oe), .pin_o(port_control_pin_o),
                        .fault(fault), .irq_ask(irq_ask),
                        .pin_level(port_control_pin_i), .irq_n(irq_in_n));
  // open-drain interrupt line with its pull-up
  assign int_wire = int_out_oe ? int_out_o : 1'b1;

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : step

  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic do_reset(input int n);
    rstn = 1'b0;
    step(n);
    rstn = 1'b1;
  endtask : do_reset

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_edge();
    {config_done, hub_connect_in, strap_in} = {2'h2, 4'hA};
    // power-on reset: the external pulse width limit does not apply here
    do_reset(6);
    step(4);
    chk("comm", 4'h0, 4'(comm_stage));
    chk("strap", 4'hA, strap_q);
    hub_connect_in = 1'b1;
    strap_in = 4'h5;
    step(2);
    chk("comm", 4'h1, 4'(comm_stage));
    chk("strap", 4'hA, strap_q);
    $display("edge test done");
  endtask : t_edge

  task automatic t_tied();
    config_done = 1'b0;
    do_reset(hsbc_pkg::RST_MIN_CYC);
    step(4);
    chk("comm", 4'h0, 4'(comm_stage));
    chk("strap", 4'h5, strap_q);
    config_done = 1'b1;
    // hold connect and config high long enough for the tied-high check to arm
    step(4);
    chk("comm", 4'h1, 4'(comm_stage));
    hub_connect_in = 1'b0;
    step(2);
    chk("comm", 4'h0, 4'(comm_stage));
    $display("tied test done");
  endtask : t_tied

  task automatic t_misc();
    for (int i = 0; i < 4; i++) begin
      {suspend_enable, hub_suspended} = 2'(i);
      charger_cfg = 2'(i);
      {irq_ask, int_pending} = {2{i[0]}};
      step(2);
      chk("susp", 4'(i == 3), 4'(suspend_out));
      chk("chg", 4'(i), {2'h0, charger_detect_bit1, charger_detect_bit0});
      chk("irq", 4'(i[0]), 4'(irq_req));
      chk("int", 4'(!i[0]), 4'(int_wire));
    end
    hub_suspended = 1'b0;
    step(2);
    chk("susp", 4'h0, 4'(suspend_out));
    $display("misc test done");
  endtask : t_misc

  task automatic t_port();
    chk("pin", 4'h0, 4'(port_control_pin_i));
    port_power_enable = 1'b1;
    step(6);
    chk("pin", 4'h1, 4'(port_control_pin_i));
    chk("oc", 4'h0, 4'(port_overcurrent));
    fault = 1'b1;
    step(6);
    chk("oc", 4'h1, 4'(port_overcurrent));
    port_power_enable = 1'b0;
    step(6);
    chk("oc", 4'h0, 4'(port_overcurrent));
    $display("port test done");
  endtask : t_port

  initial begin
    {suspend_enable, hub_suspended, int_pending, port_power_enable} = 4'h0;
    {fault, irq_ask, charger_cfg} = 4'h0;
    bad_count = 0;
    tests_run = 0;
    t_edge();
    t_tied();
    t_misc();
    t_port();
    give_verdict();
  end

  // the tests need under 200 cycles, so 4000 only trips on a hang
  initial begin
    #400000;
    bad_count++;
    give_verdict();
  end
endmodule : hsbc_tb_top
